/* logic/twi_params.svh */
// constants for the two-wire master and slave controller
`ifndef TWI_PARAMS_SVH
`define TWI_PARAMS_SVH
`define TWI_MSA_OFF   12'h000
`define TWI_MCS_OFF   12'h004
`define TWI_MDR_OFF   12'h008
`define TWI_MTPR_OFF  12'h00c
`define TWI_MIMR_OFF  12'h010
`define TWI_MRIS_OFF  12'h014
`define TWI_MMIS_OFF  12'h018
`define TWI_MICR_OFF  12'h01c
`define TWI_MCR_OFF   12'h020
`define TWI_SOAR_OFF  12'h800
`define TWI_SCSR_OFF  12'h804
`define TWI_SDR_OFF   12'h808
`define TWI_SIMR_OFF  12'h80c
`define TWI_SRIS_OFF  12'h810
`define TWI_SMIS_OFF  12'h814
`define TWI_SICR_OFF  12'h818
`define TWI_MCS_BUSY  0
`define TWI_MCS_ERR   1
`define TWI_MCS_ADRN  2
`define TWI_MCS_DATN  3
`define TWI_MCS_ARB   4
`define TWI_MCS_IDLE  5
`define TWI_MCS_BBSY  6
`define TWI_MCR_LOOPBACK_BIT  0
`define TWI_MCR_MFE   4
`define TWI_MCR_SFE   5
`define TWI_IRQ_BIT   0
`define TWI_SCSR_RECEIVE_REQUEST_FLAG 0
`define TWI_SCSR_TRANSMIT_REQUEST_FLAG 1
`define TWI_SCSR_FBR  2
`define TWI_MTPR_RST  8'h01
`define TWI_CLOCK_LOW_PHASE_COUNT    12'h006
`define TWI_CLOCK_HIGH_PHASE_COUNT    12'h004
`define TWI_ACK_SLOT  4'h8
`endif

/* logic/twi_pkg.sv */
// types shared by the two-wire controller
package twi_pkg;
  typedef enum logic [3:0] {
    M_IDLE, M_WAITBUS, M_START, M_LOW, M_HIGH, M_HOLD,
    M_RS_L, M_RS_H, M_STOP_L, M_STOP_H
  } mst_state_e;
  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_RX, S_TX} slv_state_e;
  typedef struct packed {
    logic ack;
    logic stop;
    logic start;
    logic run;
  } mcs_cmd_s;
  typedef struct packed {
    logic scl;
    logic sda;
  } line_s;
endpackage : twi_pkg

/* logic/twi_ctrl.sv */
// two-wire bus master and slave controller with apb register access
`timescale 1ns/1ns
`include "twi_params.svh"
module twi_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             m_irq,
  output logic             s_irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]             scl_s_r;
  logic [1:0]             sda_s_r;
  twi_pkg::line_s         ln;
  twi_pkg::line_s         ln_prev_r;
  logic                   bus_busy_r;
  logic                   start_det;
  logic                   stop_det;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   bus_idle;
  logic [7:0]             msa_r;
  logic [7:0]             mtx_r;
  logic [7:0]             tpr_r;
  logic                   mimr_r;
  logic                   loopback_bit_r;
  logic                   mfe_r;
  logic                   sfe_r;
  logic [6:0]             soar_r;
  logic                   simr_r;
  logic                   m_ris_r;
  logic                   s_ris_r;
  logic                   acc;
  logic                   wr;
  logic                   rd;
  logic                   cmd_go;
  twi_pkg::mcs_cmd_s      cmd;
  logic [31:0]            rd_v;
  logic                   hit;
  twi_pkg::mst_state_e    m_st_r;
  logic [11:0]            m_cnt_r;
  logic [3:0]             m_bit_r;
  logic [7:0]             m_sh_r;
  logic [7:0]             m_rx_r;
  logic                   m_addr_ph_r;
  logic                   m_rs_r;
  logic                   m_ack_r;
  logic                   m_stop_r;
  logic                   m_scl_pull_r;
  logic                   m_sda_pull_r;
  logic                   m_busy_r;
  logic                   m_err_r;
  logic                   m_adrn_r;
  logic                   m_datn_r;
  logic                   m_arb_r;
  logic                   m_done_r;
  logic                   m_tx;
  logic                   m_wait_hi;
  logic                   m_tick;
  logic                   m_drive;
  logic [11:0]            tp1;
  logic [11:0]            lo_load;
  logic [11:0]            hi_load;
  twi_pkg::slv_state_e    s_st_r;
  logic [3:0]             s_cnt_r;
  logic [7:0]             s_sh_r;
  logic [7:0]             s_rx_r;
  logic                   s_rw_r;
  logic                   s_sda_pull_r;
  logic                   s_scl_pull_r;
  logic                   s_receive_request_flag_r;
  logic                   s_transmit_request_flag_r;
  logic                   s_fbr_r;
  logic                   s_first_r;
  logic                   s_ack_r;
  logic                   s_evt_r;
  logic                   sdr_rd;
  logic                   sdr_wr;

  ////////////////////////////////////////////////////////////////////////////
  // line synchronisers and bus condition detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
    end
  end

  // loopback joins both ends internally, pins released
  assign ln.scl = loopback_bit_r ? ~(m_scl_pull_r | s_scl_pull_r) : scl_s_r[1];
  assign ln.sda = loopback_bit_r ? ~(m_sda_pull_r | s_sda_pull_r) : sda_s_r[1];
  assign start_det = ln.scl & ln_prev_r.scl & ln_prev_r.sda & ~ln.sda;
  assign stop_det  = ln.scl & ln_prev_r.scl & ~ln_prev_r.sda & ln.sda;
  assign scl_rise  = ln.scl & ~ln_prev_r.scl;
  assign scl_fall  = ~ln.scl & ln_prev_r.scl;
  assign bus_idle  = ln.scl & ln.sda & ~bus_busy_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ln_prev_r  <= 2'h3;
      bus_busy_r <= 1'b0;
    end else begin
      ln_prev_r <= ln;
      if (start_det) begin
        bus_busy_r <= 1'b1;
      end else if (stop_det) begin
        bus_busy_r <= 1'b0;
      end
    end
  end

  // open-drain pads: output level fixed low, enable pulls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_o  <= 1'b0;
      sda_o  <= 1'b0;
      scl_oe <= ~loopback_bit_r & (m_scl_pull_r | s_scl_pull_r);
      sda_oe <= ~loopback_bit_r & (m_sda_pull_r | s_sda_pull_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  assign acc    = psel & penable & pready;
  assign wr     = acc & pwrite;
  assign rd     = acc & ~pwrite;
  assign cmd_go = wr && (paddr == `TWI_MCS_OFF);
  assign cmd    = twi_pkg::mcs_cmd_s'(pwdata[3:0]);
  assign sdr_rd = rd && (paddr == `TWI_SDR_OFF);
  assign sdr_wr = wr && (paddr == `TWI_SDR_OFF);

  always_comb begin
    rd_v = 32'h0000_0000;
    hit  = 1'b1;
    case (paddr)
      `TWI_MSA_OFF:  rd_v[7:0] = msa_r;
      `TWI_MCS_OFF: begin
        rd_v[`TWI_MCS_BUSY] = m_busy_r;
        rd_v[`TWI_MCS_ERR]  = m_err_r;
        rd_v[`TWI_MCS_ADRN] = m_adrn_r;
        rd_v[`TWI_MCS_DATN] = m_datn_r;
        rd_v[`TWI_MCS_ARB]  = m_arb_r;
        rd_v[`TWI_MCS_IDLE] = (m_st_r == twi_pkg::M_IDLE);
        rd_v[`TWI_MCS_BBSY] = bus_busy_r;
      end
      `TWI_MDR_OFF:  rd_v[7:0] = m_rx_r;
      `TWI_MTPR_OFF: rd_v[7:0] = tpr_r;
      `TWI_MIMR_OFF: rd_v[`TWI_IRQ_BIT] = mimr_r;
      `TWI_MRIS_OFF: rd_v[`TWI_IRQ_BIT] = m_ris_r;
      `TWI_MMIS_OFF: rd_v[`TWI_IRQ_BIT] = m_ris_r & mimr_r;
      `TWI_MICR_OFF: rd_v = 32'h0000_0000;
      `TWI_MCR_OFF: begin
        rd_v[`TWI_MCR_LOOPBACK_BIT] = loopback_bit_r;
        rd_v[`TWI_MCR_MFE]  = mfe_r;
        rd_v[`TWI_MCR_SFE]  = sfe_r;
      end
      `TWI_SOAR_OFF: rd_v[6:0] = soar_r;
      `TWI_SCSR_OFF: begin
        rd_v[`TWI_SCSR_RECEIVE_REQUEST_FLAG] = s_receive_request_flag_r;
        rd_v[`TWI_SCSR_TRANSMIT_REQUEST_FLAG] = s_transmit_request_flag_r;
        rd_v[`TWI_SCSR_FBR]  = s_fbr_r;
      end
      `TWI_SDR_OFF:  rd_v[7:0] = s_rx_r;
      `TWI_SIMR_OFF: rd_v[`TWI_IRQ_BIT] = simr_r;
      `TWI_SRIS_OFF: rd_v[`TWI_IRQ_BIT] = s_ris_r;
      `TWI_SMIS_OFF: rd_v[`TWI_IRQ_BIT] = s_ris_r & simr_r;
      `TWI_SICR_OFF: rd_v = 32'h0000_0000;
      default:       hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~hit;
      prdata  <= pwrite ? 32'h0000_0000 : rd_v;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msa_r  <= 8'h00;
      mtx_r  <= 8'h00;
      tpr_r  <= `TWI_MTPR_RST;
      mimr_r <= 1'b0;
      loopback_bit_r <= 1'b0;
      mfe_r  <= 1'b0;
      sfe_r  <= 1'b0;
      soar_r <= 7'h00;
      simr_r <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `TWI_MSA_OFF:  msa_r  <= pwdata[7:0];
        `TWI_MDR_OFF:  mtx_r  <= pwdata[7:0];
        `TWI_MTPR_OFF: tpr_r  <= pwdata[7:0];
        `TWI_MIMR_OFF: mimr_r <= pwdata[`TWI_IRQ_BIT];
        `TWI_MCR_OFF: begin
          loopback_bit_r <= pwdata[`TWI_MCR_LOOPBACK_BIT];
          mfe_r  <= pwdata[`TWI_MCR_MFE];
          sfe_r  <= pwdata[`TWI_MCR_SFE];
        end
        `TWI_SOAR_OFF: soar_r <= pwdata[6:0];
        `TWI_SIMR_OFF: simr_r <= pwdata[`TWI_IRQ_BIT];
        default:       simr_r <= simr_r;
      endcase
    end
  end

  // interrupt flags, a set beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_ris_r <= 1'b0;
      s_ris_r <= 1'b0;
      m_irq   <= 1'b0;
      s_irq   <= 1'b0;
    end else begin
      if (m_done_r) begin
        m_ris_r <= 1'b1;
      end else if (wr && paddr == `TWI_MICR_OFF && pwdata[`TWI_IRQ_BIT]) begin
        m_ris_r <= 1'b0;
      end
      if (s_evt_r) begin
        s_ris_r <= 1'b1;
      end else if (wr && paddr == `TWI_SICR_OFF && pwdata[`TWI_IRQ_BIT]) begin
        s_ris_r <= 1'b0;
      end
      m_irq <= m_ris_r & mimr_r;
      s_irq <= s_ris_r & simr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // master clock timing
  assign tp1     = {4'h0, tpr_r} + 12'h001;
  assign lo_load = tp1 * `TWI_CLOCK_LOW_PHASE_COUNT * 12'h002 - 12'h001;
  assign hi_load = tp1 * `TWI_CLOCK_HIGH_PHASE_COUNT * 12'h002 - 12'h001;
  assign m_tx    = m_addr_ph_r | ~m_rs_r;
  assign m_wait_hi = (m_st_r == twi_pkg::M_HIGH) || (m_st_r == twi_pkg::M_RS_H) ||
                     (m_st_r == twi_pkg::M_STOP_H);
  assign m_tick  = (m_cnt_r == 12'h000) && (ln.scl || !m_wait_hi);
  // ack slot: transmitter releases, receiver acks when the command ack bit is set
  assign m_drive = (m_bit_r == `TWI_ACK_SLOT) ? (~m_tx & m_ack_r)
                                                : (m_tx & ~m_sh_r[7]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_st_r       <= twi_pkg::M_IDLE;
      m_cnt_r      <= 12'h000;
      m_bit_r      <= 4'h0;
      m_sh_r       <= 8'h00;
      m_rx_r       <= 8'h00;
      m_addr_ph_r  <= 1'b0;
      m_rs_r       <= 1'b0;
      m_ack_r      <= 1'b0;
      m_stop_r     <= 1'b0;
      m_scl_pull_r <= 1'b0;
      m_sda_pull_r <= 1'b0;
      m_busy_r     <= 1'b0;
      m_err_r      <= 1'b0;
      m_adrn_r     <= 1'b0;
      m_datn_r     <= 1'b0;
      m_arb_r      <= 1'b0;
      m_done_r     <= 1'b0;
    end else begin
      m_done_r <= 1'b0;
      if (m_cnt_r != 12'h000 && (ln.scl || !m_wait_hi)) begin
        m_cnt_r <= m_cnt_r - 12'h001;
      end
      case (m_st_r)
        twi_pkg::M_IDLE: begin
          if (cmd_go && cmd.run && cmd.start && mfe_r) begin
            m_stop_r    <= cmd.stop;
            m_ack_r     <= cmd.ack;
            m_rs_r      <= msa_r[0];
            m_sh_r      <= msa_r;
            m_addr_ph_r <= 1'b1;
            m_busy_r    <= 1'b1;
            m_err_r     <= 1'b0;
            m_adrn_r    <= 1'b0;
            m_datn_r    <= 1'b0;
            m_arb_r     <= 1'b0;
            m_st_r      <= twi_pkg::M_WAITBUS;
          end
        end
        twi_pkg::M_WAITBUS: begin
          if (bus_idle) begin
            m_sda_pull_r <= 1'b1;
            m_cnt_r      <= hi_load;
            m_st_r       <= twi_pkg::M_START;
          end
        end
        twi_pkg::M_START: begin
          if (m_tick) begin
            m_scl_pull_r <= 1'b1;
            m_cnt_r      <= lo_load;
            m_bit_r      <= 4'h0;
            m_st_r       <= twi_pkg::M_LOW;
          end
        end
        twi_pkg::M_LOW: begin
          if (m_cnt_r == hi_load) begin
            m_sda_pull_r <= m_drive;
          end
          if (m_tick) begin
            m_scl_pull_r <= 1'b0;
            m_cnt_r      <= hi_load;
            m_st_r       <= twi_pkg::M_HIGH;
          end
        end
        twi_pkg::M_HIGH: begin
          if (ln.scl && m_tx && m_bit_r != `TWI_ACK_SLOT && !m_sda_pull_r && !ln.sda) begin
            m_scl_pull_r <= 1'b0;
            m_sda_pull_r <= 1'b0;
            m_arb_r      <= 1'b1;
            m_busy_r     <= 1'b0;
            m_done_r     <= 1'b1;
            m_st_r       <= twi_pkg::M_IDLE;
          end else if (m_tick) begin
            m_scl_pull_r <= 1'b1;
            m_cnt_r      <= lo_load;
            if (m_bit_r != `TWI_ACK_SLOT) begin
              m_sh_r  <= {m_sh_r[6:0], ln.sda};
              m_bit_r <= m_bit_r + 4'h1;
              m_st_r  <= twi_pkg::M_LOW;
            end else if (m_tx && ln.sda) begin
              m_err_r <= 1'b1;
              if (m_addr_ph_r) begin
                m_adrn_r <= 1'b1;
              end else begin
                m_datn_r <= 1'b1;
              end
              m_st_r <= twi_pkg::M_STOP_L;
            end else if (m_addr_ph_r) begin
              m_addr_ph_r <= 1'b0;
              m_sh_r      <= m_rs_r ? 8'h00 : mtx_r;
              m_bit_r     <= 4'h0;
              m_st_r      <= twi_pkg::M_LOW;
            end else begin
              if (!m_tx) begin
                m_rx_r <= m_sh_r;
              end
              m_done_r <= 1'b1;
              if (m_stop_r) begin
                m_st_r <= twi_pkg::M_STOP_L;
              end else begin
                m_busy_r <= 1'b0;
                m_st_r   <= twi_pkg::M_HOLD;
              end
            end
          end
        end
        twi_pkg::M_HOLD: begin
          if (cmd_go && cmd.run && mfe_r) begin
            m_stop_r <= cmd.stop;
            m_ack_r  <= cmd.ack;
            m_busy_r <= 1'b1;
            m_err_r  <= 1'b0;
            m_adrn_r <= 1'b0;
            m_datn_r <= 1'b0;
            m_cnt_r  <= lo_load;
            m_bit_r  <= 4'h0;
            if (cmd.start) begin
              m_rs_r      <= msa_r[0];
              m_sh_r      <= msa_r;
              m_addr_ph_r <= 1'b1;
              m_st_r      <= twi_pkg::M_RS_L;
            end else begin
              m_sh_r <= m_rs_r ? 8'h00 : mtx_r;
              m_st_r <= twi_pkg::M_LOW;
            end
          end else if (cmd_go && cmd.stop) begin
            m_busy_r <= 1'b1;
            m_cnt_r  <= lo_load;
            m_st_r   <= twi_pkg::M_STOP_L;
          end
        end
        twi_pkg::M_RS_L: begin
          if (m_cnt_r == hi_load) begin
            m_sda_pull_r <= 1'b0;
          end
          if (m_tick) begin
            m_scl_pull_r <= 1'b0;
            m_cnt_r      <= hi_load;
            m_st_r       <= twi_pkg::M_RS_H;
          end
        end
        twi_pkg::M_RS_H: begin
          if (m_tick) begin
            m_sda_pull_r <= 1'b1;
            m_cnt_r      <= hi_load;
            m_st_r       <= twi_pkg::M_START;
          end
        end
        twi_pkg::M_STOP_L: begin
          if (m_cnt_r == hi_load) begin
            m_sda_pull_r <= 1'b1;
          end
          if (m_tick) begin
            m_scl_pull_r <= 1'b0;
            m_cnt_r      <= hi_load;
            m_st_r       <= twi_pkg::M_STOP_H;
          end
        end
        twi_pkg::M_STOP_H: begin
          if (m_tick) begin
            m_sda_pull_r <= 1'b0;
            m_busy_r     <= 1'b0;
            m_done_r     <= m_err_r;
            m_st_r       <= twi_pkg::M_IDLE;
          end
        end
        default: m_st_r <= twi_pkg::M_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slave engine, acts on clock edges seen on the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_st_r       <= twi_pkg::S_IDLE;
      s_cnt_r      <= 4'h0;
      s_sh_r       <= 8'h00;
      s_rx_r       <= 8'h00;
      s_rw_r       <= 1'b0;
      s_sda_pull_r <= 1'b0;
      s_scl_pull_r <= 1'b0;
      s_receive_request_flag_r     <= 1'b0;
      s_transmit_request_flag_r     <= 1'b0;
      s_fbr_r      <= 1'b0;
      s_first_r    <= 1'b0;
      s_ack_r      <= 1'b0;
      s_evt_r      <= 1'b0;
    end else begin
      s_evt_r <= 1'b0;
      if (sdr_rd) begin
        s_receive_request_flag_r <= 1'b0;
        s_fbr_r  <= 1'b0;
      end
      if (sdr_wr && s_transmit_request_flag_r) begin
        s_transmit_request_flag_r     <= 1'b0;
        s_sh_r       <= pwdata[7:0];
        s_sda_pull_r <= ~pwdata[7];
      end
      if (s_scl_pull_r && !s_receive_request_flag_r && !s_transmit_request_flag_r) begin
        s_scl_pull_r <= 1'b0;
      end
      if (start_det && sfe_r) begin
        s_st_r       <= twi_pkg::S_ADDR;
        s_cnt_r      <= 4'h0;
        s_first_r    <= 1'b1;
        s_sda_pull_r <= 1'b0;
        s_scl_pull_r <= 1'b0;
      end else if (stop_det) begin
        s_st_r       <= twi_pkg::S_IDLE;
        s_sda_pull_r <= 1'b0;
        s_scl_pull_r <= 1'b0;
      end else begin
        case (s_st_r)
          twi_pkg::S_ADDR, twi_pkg::S_RX: begin
            if (scl_rise && s_cnt_r < `TWI_ACK_SLOT) begin
              s_sh_r  <= {s_sh_r[6:0], ln.sda};
              s_cnt_r <= s_cnt_r + 4'h1;
            end
            if (scl_fall && s_cnt_r == `TWI_ACK_SLOT) begin
              if (s_st_r == twi_pkg::S_RX) begin
                s_sda_pull_r <= 1'b1;
                s_rx_r       <= s_sh_r;
                s_receive_request_flag_r     <= 1'b1;
                s_fbr_r      <= s_first_r;
                s_first_r    <= 1'b0;
                s_evt_r      <= 1'b1;
                s_cnt_r      <= 4'h9;
              end else if (s_sh_r[7:1] == soar_r) begin
                s_sda_pull_r <= 1'b1;
                s_rw_r       <= s_sh_r[0];
                s_cnt_r      <= 4'h9;
              end else begin
                s_st_r <= twi_pkg::S_IDLE;
              end
            end
            if (scl_fall && s_cnt_r == 4'h9) begin
              s_sda_pull_r <= 1'b0;
              s_cnt_r      <= 4'h0;
              if (s_st_r == twi_pkg::S_RX) begin
                s_scl_pull_r <= s_receive_request_flag_r;
              end else if (s_rw_r) begin
                s_transmit_request_flag_r     <= 1'b1;
                s_evt_r      <= 1'b1;
                s_scl_pull_r <= 1'b1;
                s_st_r       <= twi_pkg::S_TX;
              end else begin
                s_st_r <= twi_pkg::S_RX;
              end
            end
          end
          twi_pkg::S_TX: begin
            if (scl_rise) begin
              if (s_cnt_r == `TWI_ACK_SLOT) begin
                s_ack_r <= ~ln.sda;
                s_cnt_r <= 4'h9;
              end else begin
                s_cnt_r <= s_cnt_r + 4'h1;
              end
            end
            if (scl_fall) begin
              if (s_cnt_r != 4'h0 && s_cnt_r < `TWI_ACK_SLOT) begin
                s_sh_r       <= {s_sh_r[6:0], 1'b0};
                s_sda_pull_r <= ~s_sh_r[6];
              end else if (s_cnt_r == `TWI_ACK_SLOT) begin
                s_sda_pull_r <= 1'b0;
              end else if (s_cnt_r == 4'h9) begin
                s_cnt_r <= 4'h0;
                if (s_ack_r) begin
                  s_transmit_request_flag_r     <= 1'b1;
                  s_evt_r      <= 1'b1;
                  s_scl_pull_r <= 1'b1;
                end else begin
                  s_st_r <= twi_pkg::S_IDLE;
                end
              end
            end
          end
          default: s_st_r <= twi_pkg::S_IDLE;
        endcase
      end
    end
  end
endmodule : twi_ctrl

/* tb/twi_ctrl_chk.sv */
// port checker for the two-wire controller
`timescale 1ns/1ns
`include "twi_params.svh"
module twi_ctrl_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        m_irq,
  input wire logic        s_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pready && pwrite;
  property p_open; scl_o == 1'b0 && sda_o == 1'b0; endproperty
  a_open: assert property (p_open) else $error("line driven high");
  property p_wait; psel && $rose(penable) |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_err0; pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  a_err0: assert property (p_err0) else $error("unmapped read not zero");
  property p_low; $rose(scl_oe) |-> scl_oe [*8]; endproperty
  a_low: assert property (p_low) else $error("clock low too short");
  property p_high; $fell(scl_oe) |-> !scl_oe [*4]; endproperty
  a_high: assert property (p_high) else $error("clock high too short");
  property p_mm; wr && paddr == `TWI_MIMR_OFF && !pwdata[0] |=> ##1 !m_irq; endproperty
  a_mm: assert property (p_mm) else $error("master irq not masked");
  property p_sm; wr && paddr == `TWI_SIMR_OFF && !pwdata[0] |=> ##1 !s_irq; endproperty
  a_sm: assert property (p_sm) else $error("slave irq not masked");
endmodule : twi_ctrl_chk
bind twi_ctrl twi_ctrl_chk u_twi_ctrl_chk (.*);

/* tb/twi_tgt_model.sv */
// behavioural two-wire target that acks and captures bytes
`timescale 1ns/1ns
module twi_tgt_model (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic        ack_en,
  output logic             sda_oe,
  output logic [15:0]      rx
);
  int         cnt;
  logic [7:0] sh;
  initial begin
    {sda_oe, rx, sh} = '0;
    cnt = 0;
  end
  always @(negedge sda) if (scl) cnt = 0;
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  always @(negedge scl) begin
    if (cnt == 8) begin
      rx = {rx[7:0], sh};
      sda_oe = ack_en;
    end else if (cnt == 9) begin
      sda_oe = 1'b0;
      cnt = 0;
    end
  end
endmodule : twi_tgt_model

/* tb/tb_top.sv */
// testbench for the two-wire controller
`timescale 1ns/1ns
`include "twi_params.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        scl_o, scl_oe, sda_o, sda_oe, m_irq, s_irq, sda_oe_m, ack_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx;
  int          mismatches, total_checks, cyc;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | sda_oe_m);
  twi_ctrl u_twi_ctrl (.*, .scl_i(scl), .sda_i(sda));
  twi_tgt_model u_twi_tgt_model (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_oe(sda_oe_m),
                                 .rx(rx));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic poll(input logic [11:0] a, input int b, input logic v);
    do apb(1'b0, a, 0); while (rd[b] !== v);
  endtask : poll
  task automatic run(input logic [31:0] d);
    apb(1'b1, `TWI_MSA_OFF, 32'h0000_0076);
    apb(1'b1, `TWI_MDR_OFF, d);
    apb(1'b1, `TWI_MCS_OFF, 32'h0000_0007);
  endtask : run
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) if (++cyc == 40000) begin
    mismatches++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ack_en} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `TWI_MTPR_OFF, 0);
    `CHK("tpr_reset", 32'h0000_0001, rd)
    apb(1'b0, 12'h040, 0);
    `CHK("unmapped", 1'b1, err)
    apb(1'b1, `TWI_MTPR_OFF, 0);
    apb(1'b1, `TWI_MCR_OFF, 32'h0000_0010);
    ack_en <= 1'b1;
    run(32'h0000_00a5);
    poll(`TWI_MRIS_OFF, 0, 1'b1);
    poll(`TWI_MCS_OFF, `TWI_MCS_BBSY, 1'b0);
    `CHK("tx_bytes", 16'h76a5, rx)
    `CHK("m_irq_masked", 1'b0, m_irq)
    apb(1'b1, `TWI_MIMR_OFF, 32'h0000_0001);
    apb(1'b0, `TWI_MMIS_OFF, 0);
    `CHK("mmis", 32'h0000_0001, rd)
    `CHK("m_irq", 1'b1, m_irq)
    apb(1'b1, `TWI_MICR_OFF, 32'h0000_0001);
    apb(1'b0, `TWI_MRIS_OFF, 0);
    `CHK("mris_clr", 32'h0000_0000, rd)
    ack_en <= 1'b0;
    run(32'h0000_00a5);
    poll(`TWI_MRIS_OFF, 0, 1'b1);
    poll(`TWI_MCS_OFF, `TWI_MCS_BBSY, 1'b0);
    `CHK("nack_err", 2'b11, {rd[`TWI_MCS_ADRN], rd[`TWI_MCS_ERR]})
    apb(1'b1, `TWI_MIMR_OFF, 32'h0000_0000);
    apb(1'b0, `TWI_MRIS_OFF, 0);
    `CHK("mris_masked", 32'h0000_0001, rd)
    `CHK("m_irq_off", 1'b0, m_irq)
    apb(1'b1, `TWI_MICR_OFF, 32'h0000_0001);
    apb(1'b1, `TWI_MCR_OFF, 32'h0000_0031);
    apb(1'b1, `TWI_SOAR_OFF, 32'h0000_003b);
    apb(1'b1, `TWI_SIMR_OFF, 32'h0000_0001);
    run(32'h0000_005a);
    poll(`TWI_SRIS_OFF, 0, 1'b1);
    apb(1'b0, `TWI_SCSR_OFF, 0);
    `CHK("slv_flags", 32'h0000_0005, rd)
    `CHK("s_irq", 1'b1, s_irq)
    apb(1'b1, `TWI_SIMR_OFF, 32'h0000_0000);
    apb(1'b0, `TWI_SDR_OFF, 0);
    `CHK("slv_data", 32'h0000_005a, rd)
    `CHK("s_irq_off", 1'b0, s_irq)
    apb(1'b1, `TWI_SICR_OFF, 32'h0000_0001);
    apb(1'b0, `TWI_SRIS_OFF, 0);
    `CHK("sris_clr", 32'h0000_0000, rd)
    poll(`TWI_MRIS_OFF, 0, 1'b1);
    apb(1'b0, `TWI_MCS_OFF, 0);
    `CHK("loopback_bit_err", 1'b0, rd[`TWI_MCS_ERR])
    apb(1'b1, `TWI_MICR_OFF, 32'h0000_0001);
    apb(1'b1, `TWI_MSA_OFF, 32'h0000_0077);
    apb(1'b1, `TWI_MCS_OFF, 32'h0000_0007);
    poll(`TWI_SRIS_OFF, 0, 1'b1);
    apb(1'b0, `TWI_SCSR_OFF, 0);
    `CHK("slv_transmit_request_flag", 32'h0000_0002, rd)
    apb(1'b1, `TWI_SDR_OFF, 32'h0000_00c3);
    poll(`TWI_MRIS_OFF, 0, 1'b1);
    apb(1'b0, `TWI_MDR_OFF, 0);
    `CHK("mst_rx", 32'h0000_00c3, rd)
    wrap_up();
  end
endmodule : tb_top
